// file: hw/bank_regs.sv
// one bank: direction and stored value bytes, written on per-bank strobes decoded by the port
module bank_regs #(
  parameter logic [7:0] IMPL_MASK = 8'hFF  // implemented bits of this bank
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       dir_we,
  input  wire logic       val_we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] pin_level,
  output logic      [7:0] dir_q,
  output logic      [7:0] val_q,
  output logic      [7:0] dir_rd,
  output logic      [7:0] val_rd
);

  // direction: cleared at reset so every pin starts as an input
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_q <= gpio_port_pkg::DIRECTION_RESET & IMPL_MASK;
    end else if (dir_we) begin
      dir_q <= wdata & IMPL_MASK;
    end
  end

  // stored value: written in either mode, reset high
  always_ff @(posedge clk) begin
    if (srst) begin
      val_q <= gpio_port_pkg::VALUE_RESET & IMPL_MASK;
    end else if (val_we) begin
      val_q <= wdata & IMPL_MASK;
    end
  end

  // readback: direction as written, value per bit by mode
  assign dir_rd = dir_q;
  // output bits show the register, input bits show the synchronised pin
  assign val_rd = ((dir_q & val_q) | (~dir_q & pin_level)) & IMPL_MASK;

endmodule  // bank_regs

// file: hw/four_bank_bidir_pin_port.sv
// Added by the designer: the plain strobed port.
module four_bank_bidir_pin_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [23:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  bank_zero_pins_in,
  output logic      [7:0]  bank_zero_pins_out,
  output logic      [7:0]  bank_zero_pins_oe,
  output logic      [7:0]  bank_zero_pins_pu,
  input  wire logic [7:0]  bank_one_pins_in,
  output logic      [7:0]  bank_one_pins_out,
  output logic      [7:0]  bank_one_pins_oe,
  output logic      [7:0]  bank_one_pins_pu,
  input  wire logic [3:0]  bank_two_pins_in,
  output logic      [3:0]  bank_two_pins_out,
  output logic      [3:0]  bank_two_pins_oe,
  output logic      [3:0]  bank_two_pins_pu,
  input  wire logic [7:0]  bank_three_pins_in,
  output logic      [7:0]  bank_three_pins_out,
  output logic      [7:0]  bank_three_pins_oe,
  output logic      [7:0]  bank_three_pins_pu
);

  gpio_port_pkg::reg_req_s   req;        // bundled bus request
  gpio_port_pkg::pin_drive_s drive;      // bundled pin drivers
  logic [31:0]               pin_raw;    // flat asynchronous pin levels
  logic [31:0]               pin_level;  // synchronised pin levels
  logic [31:0]               dir_all;    // direction bytes, bank-major
  logic [31:0]               val_all;    // stored values, bank-major
  logic [31:0]               dir_rd_all; // direction readback per bank
  logic [31:0]               val_rd_all; // value readback per bank
  logic                      in_block;   // address falls in the eight-byte window
  logic                      sel_value;  // value byte rather than direction byte
  logic [1:0]                bank_idx;   // bank addressed
  logic [3:0]                dir_we;     // per-bank direction write strobes
  logic [3:0]                val_we;     // per-bank value write strobes
  logic [7:0]                rd_mux;     // read data before the output flop
  logic [7:0]                rdata_q;    // registered read data

  // one-hot bank select, used for both write strobe vectors
  function automatic logic [3:0] bank_onehot(input logic [1:0] idx);
    bank_onehot = 4'h1 << idx;
  endfunction

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // narrow bank is zero-padded to eight bits; its unused inputs read as zero
  assign pin_raw = {bank_three_pins_in, 4'h0, bank_two_pins_in,
                    bank_one_pins_in, bank_zero_pins_in};

  // pins come from the board, so synchronise before any readback logic sees them
  pin_sync u_sync (
    .clk        (clk),
    .srst       (srst),
    .pin_async  (pin_raw),
    .pin_sync_q (pin_level)
  );

  // address decode: all eight registers sit in one aligned eight-byte window
  assign in_block  = (req.addr[23:3] == gpio_port_pkg::REG_BLOCK_BASE);
  assign sel_value = req.addr[gpio_port_pkg::SEL_VALUE_BIT];
  assign bank_idx  = req.addr[1:0];

  // write strobes; writes outside the window are dropped silently
  assign dir_we = (req.wr && in_block && !sel_value) ? bank_onehot(bank_idx) : 4'h0;
  assign val_we = (req.wr && in_block &&  sel_value) ? bank_onehot(bank_idx) : 4'h0;

  // one register pair per bank; bank two keeps only its low four bits
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      localparam logic [7:0] MASK = (b == gpio_port_pkg::NARROW_ID) ?
                                    gpio_port_pkg::NARROW_MASK : gpio_port_pkg::FULL_MASK;
      bank_regs #(
        .IMPL_MASK (MASK)
      ) u_bank (
        .clk       (clk),
        .srst      (srst),
        .dir_we    (dir_we[b]),
        .val_we    (val_we[b]),
        .wdata     (req.wdata),
        .pin_level (pin_level[b*8 +: 8]),
        .dir_q     (dir_all[b*8 +: 8]),
        .val_q     (val_all[b*8 +: 8]),
        .dir_rd    (dir_rd_all[b*8 +: 8]),
        .val_rd    (val_rd_all[b*8 +: 8])
      );
    end
  endgenerate

  // read select: value or direction byte of the addressed bank, zero elsewhere
  assign rd_mux = !in_block ? gpio_port_pkg::UNMAPPED_READ :
                  sel_value ? val_rd_all[bank_idx*8 +: 8] :
                              dir_rd_all[bank_idx*8 +: 8];

  // read data stand in the cycle after the strobe only, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // pin drivers: drive data only in output mode, pull up only in input mode.
  // the level is the stored bit even when disabled, so a mode switch shows the
  // value written earlier with no extra cycle
  assign drive.out = val_all;
  assign drive.oe  = dir_all;
  assign drive.pu  = ~dir_all;

  // split the flat vectors back onto the bank ports
  assign bank_zero_pins_out  = drive.out[7:0];
  assign bank_zero_pins_oe   = drive.oe[7:0];
  assign bank_zero_pins_pu   = drive.pu[7:0];
  assign bank_one_pins_out   = drive.out[15:8];
  assign bank_one_pins_oe    = drive.oe[15:8];
  assign bank_one_pins_pu    = drive.pu[15:8];
  assign bank_two_pins_out   = drive.out[19:16];
  assign bank_two_pins_oe    = drive.oe[19:16];
  assign bank_two_pins_pu    = drive.pu[19:16];
  assign bank_three_pins_out = drive.out[31:24];
  assign bank_three_pins_oe  = drive.oe[31:24];
  assign bank_three_pins_pu  = drive.pu[31:24];

  // pin_raw bits 23:20 are padding; the pull-up rise delay is software's concern

endmodule  // four_bank_bidir_pin_port

// file: hw/pin_sync.sv
// two-flop synchroniser for the pin inputs; the first stage is read only by the second
module pin_sync (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] pin_async,
  output logic      [31:0] pin_sync_q
);

  logic [31:0] meta_q;  // first stage, may be metastable

  // both stages reset to zero; the first stage feeds the second only
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q     <= '0;
      pin_sync_q <= '0;
    end else begin
      meta_q     <= pin_async;
      pin_sync_q <= meta_q;
    end
  end

endmodule  // pin_sync

// file: inc/gpio_port_pkg.sv
package gpio_port_pkg;

  // register bus widths
  localparam int unsigned ADDR_W = 24;  // byte address width of the internal register space
  localparam int unsigned DATA_W = 8;   // every register is one byte

  // bank geometry
  localparam int unsigned BANKS     = 4;
  localparam int unsigned BANK_W    = 8;  // pins per full bank
  localparam int unsigned NARROW_W  = 4;  // pins implemented in bank two
  localparam int unsigned NARROW_ID = 2;  // index of the narrow bank
  localparam int unsigned PINS      = BANKS * BANK_W;  // flat pin vector width, holes included

  // register byte addresses
  localparam logic [23:0] PIN_DIRECTION_BANK0 = 24'h00FFE0;
  localparam logic [23:0] PIN_DIRECTION_BANK1 = 24'h00FFE1;
  localparam logic [23:0] PIN_DIRECTION_BANK2 = 24'h00FFE2;
  localparam logic [23:0] PIN_DIRECTION_BANK3 = 24'h00FFE3;
  localparam logic [23:0] PIN_VALUE_BANK0     = 24'h00FFE4;
  localparam logic [23:0] PIN_VALUE_BANK1     = 24'h00FFE5;
  localparam logic [23:0] PIN_VALUE_BANK2     = 24'h00FFE6;
  localparam logic [23:0] PIN_VALUE_BANK3     = 24'h00FFE7;

  // decode fields: the eight registers share the upper address bits
  localparam logic [20:0] REG_BLOCK_BASE = 21'h001FFC;  // addr[23:3]
  localparam int unsigned SEL_VALUE_BIT  = 2;           // addr[2]: 1 = value, 0 = direction

  // reset values
  localparam logic [7:0] DIRECTION_RESET = 8'h00;  // all pins start as inputs
  localparam logic [7:0] VALUE_RESET     = 8'hFF;  // stored data starts high
  localparam logic [7:0] NARROW_MASK     = 8'h0F;  // implemented bits of bank two
  localparam logic [7:0] FULL_MASK       = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;  // answer to an unmapped address

  // synchroniser depth on the pin inputs
  localparam int unsigned SYNC_STAGES = 2;

  // register bus request
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // pin driver triple per pin vector
  typedef struct packed {
    logic [31:0] out;  // level to drive
    logic [31:0] oe;   // high while driving
    logic [31:0] pu;   // pull-up enable (input mode only)
  } pin_drive_s;

endpackage

// file: verif/board_pins.sv
// board side: driven pins follow the port, the rest the board or the pull-up
module board_pins (
  input  wire logic [31:0] drv_out,
  input  wire logic [31:0] drv_oe,
  input  wire logic [31:0] drv_pu,
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_en,
  output logic      [31:0] level
);
  // a floating pin without pull-up shows a pattern that differs from the board drive
  assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
               | (~drv_oe & ~ext_en & (drv_pu | ~ext_val));
endmodule // board_pins

// file: verif/four_bank_bidir_pin_port_test.sv
module four_bank_bidir_pin_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, reg_wr, reg_rd;
  logic [23:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, bank_zero_pins_in, bank_one_pins_in, bank_three_pins_in;
  logic [7:0]  bank_zero_pins_out, bank_zero_pins_oe, bank_zero_pins_pu, bank_one_pins_out;
  logic [7:0]  bank_one_pins_oe, bank_one_pins_pu, bank_three_pins_out, bank_three_pins_oe;
  logic [7:0]  bank_three_pins_pu, d, v, m, e, en;
  logic [3:0]  bank_two_pins_in, bank_two_pins_out, bank_two_pins_oe, bank_two_pins_pu;
  logic [31:0] lvl, ext_val, ext_en, seed;
  int          miscompares, total_checks, b;
  // flat pin vectors, bank two padded to a full byte
  wire [31:0] out32 = {bank_three_pins_out, 4'h0, bank_two_pins_out, bank_one_pins_out, bank_zero_pins_out};
  wire [31:0] oe32 = {bank_three_pins_oe, 4'h0, bank_two_pins_oe, bank_one_pins_oe, bank_zero_pins_oe};
  wire [31:0] pu32 = {bank_three_pins_pu, 4'h0, bank_two_pins_pu, bank_one_pins_pu, bank_zero_pins_pu};
  assign {bank_three_pins_in, bank_one_pins_in, bank_zero_pins_in} = {lvl[31:24], lvl[15:0]};
  assign bank_two_pins_in = lvl[19:16];
  four_bank_bidir_pin_port four_bank_bidir_pin_port_i (.*);
  board_pins board_pins_i (.drv_out(out32), .drv_oe(oe32), .drv_pu(pu32), .ext_val(ext_val),
                           .ext_en(ext_en), .level(lvl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // output bits show stored data, input bits the board level or the pull-up
  function automatic logic [7:0] pin_exp(input logic [7:0] d, v, e, en, m);
    return ((d & v) | (~d & en & e) | (~d & ~en)) & m;
  endfunction
  task automatic check(input string name, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= x;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(name, exp, reg_rdata);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000 miscompares++;
    stop_test();
  end
  initial begin
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 24'h0; reg_wdata = 8'h00;
    ext_val = 32'h0; ext_en = 32'h0; seed = 32'h199D81CF; miscompares = 0; total_checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1 check("reset level", 8'hFF, bank_one_pins_out);
    for (b = 0; b < 4; b++) begin
      rd(24'(gpio_port_pkg::PIN_DIRECTION_BANK0 + b), 8'h00, "reset dir");
      rd(24'(gpio_port_pkg::PIN_VALUE_BANK0 + b), b == 2 ? 8'h0F : 8'hFF, "released pins");
    end
    wr(24'h00FFE8, 8'hFF);
    rd(24'h00FFE8, 8'h00, "unmapped");
    // first four passes drive each bank fully as outputs, then random mixes
    for (int i = 0; i < 60; i++) begin
      b = i % 4;
      m = b == 2 ? 8'h0F : 8'hFF;
      seed = xorshift(seed);
      d = i < 4 ? 8'hFF : seed[7:0];
      v = seed[15:8];
      e = seed[23:16];
      en = i < 8 ? 8'hFF : seed[31:24];
      @(posedge clk);
      ext_val <= {4{e}};
      ext_en <= {4{en}};
      wr(24'(gpio_port_pkg::PIN_DIRECTION_BANK0 + b), d);
      wr(24'(gpio_port_pkg::PIN_VALUE_BANK0 + b), v);
      #1 check("pin oe", d & m, oe32[b*8 +: 8]);
      check("pin level", pin_exp(d, v, e, en, m), lvl[b*8 +: 8] & m);
      rd(24'(gpio_port_pkg::PIN_DIRECTION_BANK0 + b), d & m, "dir read");
      // the direction read above covers the two synchroniser stages
      rd(24'(gpio_port_pkg::PIN_VALUE_BANK0 + b), pin_exp(d, v, e, en, m), "value read");
    end
    stop_test();
  end
endmodule // four_bank_bidir_pin_port_test

// file: verif/port_props_properties.sv
// watches the register bus and pin drivers of the port
module port_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [23:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  bank_zero_pins_oe,
  input wire logic [7:0]  bank_one_pins_out,
  input wire logic [7:0]  bank_one_pins_oe,
  input wire logic [3:0]  bank_two_pins_oe,
  input wire logic [3:0]  bank_two_pins_pu,
  input wire logic [7:0]  bank_three_pins_out,
  input wire logic [7:0]  bank_three_pins_oe,
  input wire logic [7:0]  bank_three_pins_pu
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // decoded strobes for the registers watched here
  wire dir0_wr = reg_wr && reg_addr == gpio_port_pkg::PIN_DIRECTION_BANK0;
  wire dir2_wr = reg_wr && reg_addr == gpio_port_pkg::PIN_DIRECTION_BANK2;
  wire val3_wr = reg_wr && reg_addr == gpio_port_pkg::PIN_VALUE_BANK3;
  wire unmapped = reg_addr[23:3] != gpio_port_pkg::REG_BLOCK_BASE;
  a_dir_sets_oe: assert property (dir0_wr |=> bank_zero_pins_oe == $past(reg_wdata))
    else $error("bank zero enables differ from written direction");
  a_oe_holds_idle: assert property (!dir0_wr |=> $stable(bank_zero_pins_oe))
    else $error("bank zero enables moved without a write");
  a_value_drives_out: assert property (val3_wr |=> bank_three_pins_out == $past(reg_wdata))
    else $error("bank three level differs from written data");
  a_narrow_dir: assert property (dir2_wr |=> bank_two_pins_oe == $past(reg_wdata[3:0]))
    else $error("bank two enables differ from low nibble");
  a_pullup_input: assert property ((bank_three_pins_pu == ~bank_three_pins_oe) && (bank_two_pins_pu == ~bank_two_pins_oe))
    else $error("pull-up not the inverse of the enable");
  // reset itself is the cause here, so this one is not disabled by it
  a_reset_state: assert property (disable iff (1'b0) srst |=> bank_zero_pins_oe == 8'h00 && bank_three_pins_out == 8'hFF)
    else $error("pin drivers not at reset state");
  a_read_dir_back: assert property (reg_rd && reg_addr == gpio_port_pkg::PIN_DIRECTION_BANK1 |=> reg_rdata == bank_one_pins_oe)
    else $error("direction readback differs from enables");
  a_read_out_mode: assert property (reg_rd && reg_addr == gpio_port_pkg::PIN_VALUE_BANK1 && bank_one_pins_oe == 8'hFF
    |=> reg_rdata == $past(bank_one_pins_out))
    else $error("output-mode read differs from stored data");
  a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_dir_write: cover property (dir0_wr);
  c_value_write: cover property (val3_wr ##1 reg_rd);
  c_unmapped: cover property (reg_rd && unmapped);
endmodule // port_props

bind four_bank_bidir_pin_port port_props port_props_i (.*);
